// [src/gpio_ports.sv]
// GPIO block: three ports of pins with direction, function select, pulls and edge interrupts
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps

module gpio_ports
    import gpio_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  reset,
    // Register port
    input  wire logic [ADDR_WIDTH-1:0] regAddr,
    input  wire logic [DATA_WIDTH-1:0] regWriteData,
    input  wire logic                  regWrite,
    input  wire logic                  regRead,
    input  wire logic                  regReadModify,
    output logic      [DATA_WIDTH-1:0] regReadData,
    // Power management
    input  wire logic [1:0]            sleepMode,
    // Pins
    input  wire logic [PIN_COUNT-1:0]  pinIn,
    output logic      [PIN_COUNT-1:0]  pinOut,
    output logic      [PIN_COUNT-1:0]  pinOe,
    output logic      [PIN_COUNT-1:0]  pinPullUp,
    output logic      [PIN_COUNT-1:0]  pinPullDown,
    // Peripheral side
    input  wire logic [PIN_COUNT-1:0]  periphOut,
    input  wire logic [PIN_COUNT-1:0]  periphOe,
    output logic      [PIN_COUNT-1:0]  periphIn,
    // Interrupt requests toward the CPU
    output logic      [PORT_COUNT-1:0] portIrq,
    output logic                       wakeRequest
);

    // Per-pin configuration, flat layout with port p at bits 8p+7..8p
    logic [FLAT_WIDTH-1:0] portData;
    logic [FLAT_WIDTH-1:0] functionSel;
    logic [FLAT_WIDTH-1:0] direction;
    logic [FLAT_WIDTH-1:0] inputMode;
    logic [FLAT_WIDTH-1:0] pinIrqEnable;
    logic [FLAT_WIDTH-1:0] pinIrqFlag;
    logic [DATA_WIDTH-1:0] edgeControl;
    logic [PORT_COUNT-1:0] commonIrqEnable;
    logic [PORT_COUNT-1:0] pullDirection;

    // Synchroniser stages and previous level for edge detection
    logic [PIN_COUNT-1:0]  syncFirst;
    logic [PIN_COUNT-1:0]  syncSecond;
    logic [PIN_COUNT-1:0]  syncPrevious;

    // Geometry checks: the flat layout, masks and bus lanes assume these sizes
    if (PORT_COUNT != 3) begin : g_port_count_check
        $error("Block is laid out for exactly three ports");
    end
    if (PIN_COUNT != 2 * PORT_WIDTH + PORT_TWO_WIDTH) begin : g_pin_count_check
        $error("Pin count must match two full ports and a short one");
    end
    if (FLAT_WIDTH != PORT_COUNT * PORT_WIDTH) begin : g_flat_check
        $error("Flat layout must hold every port at full width");
    end
    if (DATA_WIDTH != PORT_WIDTH) begin : g_lane_check
        $error("One register must hold exactly one port");
    end
    if (ADDR_WIDTH < 5) begin : g_addr_check
        $error("Register map needs five address bits");
    end

    // Address decode: which register group and which port
    wire logic             isData     = regAddr >= ADDR_PORT_DATA
                                        && regAddr < ADDR_FUNCTION_SEL;
    wire logic             isSel      = regAddr >= ADDR_FUNCTION_SEL
                                        && regAddr < ADDR_DIRECTION;
    wire logic             isDir      = regAddr >= ADDR_DIRECTION
                                        && regAddr < ADDR_INPUT_MODE;
    wire logic             isInp      = regAddr >= ADDR_INPUT_MODE
                                        && regAddr < ADDR_PIN_IRQ_EN;
    wire logic             isIen      = regAddr >= ADDR_PIN_IRQ_EN
                                        && regAddr < ADDR_PIN_IRQ_FLAG;
    wire logic             isIfg      = regAddr >= ADDR_PIN_IRQ_FLAG
                                        && regAddr < ADDR_EDGE_CONTROL;
    wire logic             isEdge     = regAddr == ADDR_EDGE_CONTROL;
    wire logic             isCommon   = regAddr == ADDR_COMMON_IRQ_EN;
    wire logic             isPullDir  = regAddr == ADDR_PULL_DIRECTION;

    // Port index inside a group; the group base is subtracted
    wire logic [4:0]       groupBase  = isData ? ADDR_PORT_DATA
                                      : isSel  ? ADDR_FUNCTION_SEL
                                      : isDir  ? ADDR_DIRECTION
                                      : isInp  ? ADDR_INPUT_MODE
                                      : isIen  ? ADDR_PIN_IRQ_EN
                                      : ADDR_PIN_IRQ_FLAG;
    wire logic [4:0]       portDelta  = regAddr - groupBase;
    wire logic [1:0]       portIndex  = portDelta[1:0];

    // Write data placed at the addressed port, with a lane mask
    // Bit offset of the addressed port; a four-bit product would wrap port two onto zero
    wire logic [4:0]       laneShift  = {portIndex, 3'h0};
    wire logic [FLAT_WIDTH-1:0] laneMask =
        (FLAT_WIDTH'(8'hff) << laneShift) & PIN_VALID_MASK;
    wire logic [FLAT_WIDTH-1:0] laneData =
        FLAT_WIDTH'(regWriteData) << laneShift;

    wire logic             wrData     = regWrite && isData;
    wire logic             wrSel      = regWrite && isSel;
    wire logic             wrDir      = regWrite && isDir;
    wire logic             wrInp      = regWrite && isInp;
    wire logic             wrIen      = regWrite && isIen;
    wire logic             wrIfg      = regWrite && isIfg;
    wire logic             wrEdge     = regWrite && isEdge;
    wire logic             wrCommon   = regWrite && isCommon;
    wire logic             wrPullDir  = regWrite && isPullDir;

    // Lane merge for the per-pin groups: only the addressed port's real pins change
    wire logic [FLAT_WIDTH-1:0] keepMask          = ~laneMask;
    wire logic [FLAT_WIDTH-1:0] laneBits          = laneData & laneMask;
    wire logic [FLAT_WIDTH-1:0] next_portData     = (portData & keepMask) | laneBits;
    wire logic [FLAT_WIDTH-1:0] next_functionSel  = (functionSel & keepMask) | laneBits;
    wire logic [FLAT_WIDTH-1:0] next_direction    = (direction & keepMask) | laneBits;
    wire logic [FLAT_WIDTH-1:0] next_inputMode    = (inputMode & keepMask) | laneBits;
    wire logic [FLAT_WIDTH-1:0] next_pinIrqEnable = (pinIrqEnable & keepMask) | laneBits;

    // Sleep is any mode other than active
    wire logic             asleep     = sleepMode != GPIO_ACTIVE;

    // Edge polarity expanded to one bit per pin from the shared register
    wire logic [PIN_COUNT-1:0] fallingSel = {
        {PORT_TWO_WIDTH{edgeControl[EDGE_PORT_TWO]}},
        {4{edgeControl[EDGE_PORT_ONE_HIGH]}},
        {4{edgeControl[EDGE_PORT_ONE_LOW]}},
        {PORT_WIDTH{edgeControl[EDGE_PORT_ZERO]}}
    };

    // Edge detect on synchronised levels, every pin whatever its role
    wire logic [PIN_COUNT-1:0] risingSeen  = syncSecond & ~syncPrevious;
    wire logic [PIN_COUNT-1:0] fallingSeen = ~syncSecond & syncPrevious;
    wire logic [PIN_COUNT-1:0] edgeSeen    =
        (fallingSel & fallingSeen) | (~fallingSel & risingSeen);

    // Flags: software writes clear by zero, keep by one; a new edge always wins
    wire logic [FLAT_WIDTH-1:0] flagKeep =
        wrIfg ? (~laneMask | laneData) : {FLAT_WIDTH{1'b1}};
    wire logic [FLAT_WIDTH-1:0] next_pinIrqFlag =
        ((pinIrqFlag & flagKeep) | FLAT_WIDTH'(edgeSeen)) & PIN_VALID_MASK;

    // Port request: common enable and some flagged pin with its own enable
    wire logic [FLAT_WIDTH-1:0] flagEnabled = pinIrqFlag & pinIrqEnable;
    wire logic [PORT_COUNT-1:0] next_portIrq = {
        commonIrqEnable[2] && (|flagEnabled[23:16]),
        commonIrqEnable[1] && (|flagEnabled[15:8]),
        commonIrqEnable[0] && (|flagEnabled[7:0])
    };

    // Pin drive: general-purpose data and direction, or the peripheral's own
    wire logic [PIN_COUNT-1:0] selPin  = functionSel[PIN_COUNT-1:0];
    wire logic [PIN_COUNT-1:0] dirPin  = direction[PIN_COUNT-1:0];
    wire logic [PIN_COUNT-1:0] next_pinOut =
        (selPin & periphOut) | (~selPin & portData[PIN_COUNT-1:0]);
    wire logic [PIN_COUNT-1:0] next_pinOe  =
        (selPin & periphOe) | (~selPin & dirPin);

    // Pulls only on general-purpose inputs of capable pins not three-stated
    wire logic [PIN_COUNT-1:0] pullAllowed =
        ~selPin & ~dirPin & ~inputMode[PIN_COUNT-1:0]
        & PULL_CAPABLE[PIN_COUNT-1:0];
    wire logic [PIN_COUNT-1:0] pullDownPin = {
        {PORT_TWO_WIDTH{pullDirection[2]}},
        {PORT_WIDTH{pullDirection[1]}},
        {PORT_WIDTH{pullDirection[0]}}
    };
    wire logic [PIN_COUNT-1:0] next_pinPullUp   = pullAllowed & ~pullDownPin;
    wire logic [PIN_COUNT-1:0] next_pinPullDown = pullAllowed & pullDownPin;

    // Read data selection; unmapped offsets read zero
    wire logic [FLAT_WIDTH-1:0] pinLevels = FLAT_WIDTH'(syncSecond);
    wire logic [FLAT_WIDTH-1:0] dataView  =
        regReadModify ? portData : pinLevels;
    wire logic [FLAT_WIDTH-1:0] groupView =
          isData ? dataView
        : isSel  ? functionSel
        : isDir  ? direction
        : isInp  ? inputMode
        : isIen  ? pinIrqEnable
        : pinIrqFlag;
    wire logic [FLAT_WIDTH-1:0] groupShift = groupView >> laneShift;
    wire logic                  inGroup    =
        (isData || isSel || isDir || isInp || isIen || isIfg) && portIndex < 2'd3;
    wire logic [DATA_WIDTH-1:0] next_regReadData =
          inGroup   ? groupShift[DATA_WIDTH-1:0]
        : isEdge    ? edgeControl
        : isCommon  ? DATA_WIDTH'(commonIrqEnable)
        : isPullDir ? DATA_WIDTH'(pullDirection)
        : RESET_READ_DATA;

    // Two-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge mclk) begin
        syncFirst    <= pinIn;
        syncSecond   <= syncFirst;
        syncPrevious <= syncSecond;
    end

    // Data register: a write stores the value driven when the pin is an output
    always_ff @(posedge mclk) begin
        if (reset) begin
            portData <= RESET_PIN_REG;
        end else if (wrData) begin
            portData <= next_portData;
        end
    end

    // Function select and direction come up general-purpose input
    always_ff @(posedge mclk) begin
        if (reset) begin
            functionSel <= RESET_PIN_REG;
            direction   <= RESET_PIN_REG;
        end else begin
            if (wrSel) begin
                functionSel <= next_functionSel;
            end
            if (wrDir) begin
                direction <= next_direction;
            end
        end
    end

    // Input mode clear at reset means pull-up on every capable input
    always_ff @(posedge mclk) begin
        if (reset) begin
            inputMode     <= RESET_PIN_REG;
            pullDirection <= RESET_PULL_DIR;
        end else begin
            if (wrInp) begin
                inputMode <= next_inputMode;
            end
            if (wrPullDir) begin
                pullDirection <= regWriteData[PORT_COUNT-1:0];
            end
        end
    end

    // Interrupt enables and edge selection
    always_ff @(posedge mclk) begin
        if (reset) begin
            pinIrqEnable    <= RESET_PIN_REG;
            edgeControl     <= RESET_EDGE_CTL;
            commonIrqEnable <= RESET_COMMON_EN;
        end else begin
            if (wrIen) begin
                pinIrqEnable <= next_pinIrqEnable;
            end
            if (wrEdge) begin
                edgeControl <= regWriteData;
            end
            if (wrCommon) begin
                commonIrqEnable <= regWriteData[PORT_COUNT-1:0];
            end
        end
    end

    // Flags keep catching edges during sleep, so a pin can wake the chip
    always_ff @(posedge mclk) begin
        if (reset) begin
            pinIrqFlag <= RESET_PIN_REG;
        end else begin
            pinIrqFlag <= next_pinIrqFlag;
        end
    end

    // Interrupt and wake outputs; wake uses the same gating as the CPU request
    always_ff @(posedge mclk) begin
        if (reset) begin
            portIrq     <= RESET_COMMON_EN;
            wakeRequest <= 1'b0;
        end else begin
            portIrq     <= next_portIrq;
            wakeRequest <= asleep && (|next_portIrq);
        end
    end

    // Pad controls are frozen while asleep; the peripherals may be unclocked then
    always_ff @(posedge mclk) begin
        if (reset) begin
            pinOut      <= '0;
            pinOe       <= '0;
            pinPullUp   <= PULL_CAPABLE[PIN_COUNT-1:0];
            pinPullDown <= '0;
        end else if (!asleep) begin
            pinOut      <= next_pinOut;
            pinOe       <= next_pinOe;
            pinPullUp   <= next_pinPullUp;
            pinPullDown <= next_pinPullDown;
        end
    end

    // Peripherals always see the synchronised pin level
    always_ff @(posedge mclk) begin
        periphIn <= syncSecond;
    end

    // Read data stands in the cycle after the read strobe only
    always_ff @(posedge mclk) begin
        if (reset) begin
            regReadData <= RESET_READ_DATA;
        end else if (regRead) begin
            regReadData <= next_regReadData;
        end else begin
            regReadData <= RESET_READ_DATA;
        end
    end

endmodule

// [src/gpio_pkg.sv]
// Package with the register map, field layouts and reset values of the GPIO ports
package gpio_pkg;

    // Pin organisation: two full ports and one five-bit port
    localparam int PORT_COUNT      = 3;
    localparam int PORT_WIDTH      = 8;
    localparam int PIN_COUNT       = 21;
    localparam int FLAT_WIDTH      = PORT_COUNT * PORT_WIDTH;
    localparam int PORT_TWO_WIDTH  = 5;

    // Bits that exist as pins in the flat 24-bit layout
    localparam logic [23:0] PIN_VALID_MASK = 24'h1fffff;
    // Pins with pull capability (second port pins 0 and 1 have none)
    localparam logic [23:0] PULL_CAPABLE   = 24'h1ffcff;

    // Register bus geometry
    localparam int ADDR_WIDTH = 5;
    localparam int DATA_WIDTH = 8;

    // Register offsets, one per port for the per-pin groups
    localparam logic [4:0] ADDR_PORT_DATA      = 5'h00;
    localparam logic [4:0] ADDR_FUNCTION_SEL   = 5'h03;
    localparam logic [4:0] ADDR_DIRECTION      = 5'h06;
    localparam logic [4:0] ADDR_INPUT_MODE     = 5'h09;
    localparam logic [4:0] ADDR_PIN_IRQ_EN     = 5'h0c;
    localparam logic [4:0] ADDR_PIN_IRQ_FLAG   = 5'h0f;
    localparam logic [4:0] ADDR_EDGE_CONTROL   = 5'h12;
    localparam logic [4:0] ADDR_COMMON_IRQ_EN  = 5'h13;
    localparam logic [4:0] ADDR_PULL_DIRECTION = 5'h14;

    // Edge control fields: 1 selects falling edge, 0 rising edge
    localparam int EDGE_PORT_ZERO     = 0;
    localparam int EDGE_PORT_ONE_LOW  = 1;
    localparam int EDGE_PORT_ONE_HIGH = 2;
    localparam int EDGE_PORT_TWO      = 3;

    // Reset values
    localparam logic [23:0] RESET_PIN_REG   = 24'h000000;
    localparam logic [7:0]  RESET_EDGE_CTL  = 8'h00;
    localparam logic [2:0]  RESET_COMMON_EN = 3'h0;
    localparam logic [2:0]  RESET_PULL_DIR  = 3'h0;
    localparam logic [7:0]  RESET_READ_DATA = 8'h00;

    // Sleep mode encodings on the power-management input
    typedef enum logic [1:0] {
        GPIO_ACTIVE      = 2'h0,
        GPIO_SLEEP_ONE   = 2'h1,
        GPIO_SLEEP_TWO   = 2'h2,
        GPIO_SLEEP_THREE = 2'h3
    } gpio_sleep_type;

endpackage

// [bench/gpio_ports_props.sv]
// Checker of the GPIO ports block, bound to its ports
`timescale 1ns/1ps
module gpio_ports_props
    import gpio_pkg::*;
(
    input wire logic                  mclk,
    input wire logic                  reset,
    input wire logic [ADDR_WIDTH-1:0] regAddr,
    input wire logic [DATA_WIDTH-1:0] regWriteData,
    input wire logic                  regWrite,
    input wire logic                  regRead,
    input wire logic [DATA_WIDTH-1:0] regReadData,
    input wire logic [1:0]            sleepMode,
    input wire logic [PIN_COUNT-1:0]  pinIn,
    input wire logic [PIN_COUNT-1:0]  pinOut,
    input wire logic [PIN_COUNT-1:0]  pinOe,
    input wire logic [PIN_COUNT-1:0]  pinPullUp,
    input wire logic [PIN_COUNT-1:0]  pinPullDown,
    input wire logic [PIN_COUNT-1:0]  periphIn,
    input wire logic [PORT_COUNT-1:0] portIrq,
    input wire logic                  wakeRequest
);
    default clocking cb @(posedge mclk); endclocking
    // Port zero pins quiet long enough for any edge in the synchroniser to land first
    sequence quietZero;
        $stable(pinIn[7:0]) [*5];
    endsequence
    sequence clearZero;
        regWrite && regAddr == ADDR_PIN_IRQ_FLAG && regWriteData == 8'h00;
    endsequence
    // No disable here: the reset state itself is what is checked
    reset_out_a: assert property (reset |=> pinOe == '0 && pinPullDown == '0
        && portIrq == '0 && pinPullUp == PULL_CAPABLE[PIN_COUNT-1:0]) else $error("Bad reset state");
    pull_gate_a: assert property (disable iff (reset)
        ((pinPullUp | pinPullDown) & (pinOe | 21'h000300)) == '0) else $error("Pull on bad pin");
    pull_excl_a: assert property (disable iff (reset) (pinPullUp & pinPullDown) == '0)
        else $error("Both pulls on");
    sleep_hold_a: assert property (disable iff (reset) sleepMode != 2'h0 |=>
        $stable(pinOe) && $stable(pinOut) && $stable(pinPullUp)) else $error("Pins moved in sleep");
    sync_delay_a: assert property (disable iff (reset) periphIn == $past(pinIn, 3))
        else $error("Synchroniser delay wrong");
    read_idle_a: assert property (disable iff (reset)
        (!regRead || regAddr > 5'h14) |=> regReadData == 8'h00) else $error("Read data not idle");
    wake_match_a: assert property (disable iff (reset)
        wakeRequest == (portIrq != 3'h0 && $past(sleepMode) != 2'h0)) else $error("Wake wrong");
    flag_clear_a: assert property (disable iff (reset) quietZero ##0 clearZero |=> ##1
        !portIrq[0]) else $error("Cleared flags still request");
endmodule

bind gpio_ports gpio_ports_props gpio_ports_props_i (.mclk(mclk), .reset(reset),
    .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .sleepMode(sleepMode), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .pinPullUp(pinPullUp), .pinPullDown(pinPullDown), .periphIn(periphIn),
    .portIrq(portIrq), .wakeRequest(wakeRequest));

// [bench/gpio_pin_model.sv]
// Far-side pin model: resolves each pin from block drive, far-side drive and pulls
`timescale 1ns/1ps
module gpio_pin_model
    import gpio_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic [PIN_COUNT-1:0] pinOut,
    input  wire logic [PIN_COUNT-1:0] pinOe,
    input  wire logic [PIN_COUNT-1:0] pinPullUp,
    input  wire logic [PIN_COUNT-1:0] pinPullDown,
    input  wire logic [PIN_COUNT-1:0] extEn,
    input  wire logic [PIN_COUNT-1:0] extVal,
    output logic      [PIN_COUNT-1:0] pinIn
);
    logic [PIN_COUNT-1:0] lastLevel;
    // Block drive wins; a pin nobody holds wanders, so it shows its last level inverted
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (pinOe[i] === 1'b1) pinIn[i] = pinOut[i];
            else if (extEn[i]) pinIn[i] = extVal[i];
            else if (pinPullUp[i] === 1'b1) pinIn[i] = 1'b1;
            else if (pinPullDown[i] === 1'b1) pinIn[i] = 1'b0;
            else pinIn[i] = ~lastLevel[i];
        end
    end
    // Last level for the floating case
    always_ff @(posedge mclk) lastLevel <= pinIn;
endmodule

// [bench/gpio_ports_test.sv]
// Self-checking bench for the GPIO ports block
`timescale 1ns/1ps
module gpio_ports_test;
    import gpio_pkg::*;
    logic        mclk, reset, regWrite, regRead, regReadModify, wakeRequest, rdSeen;
    logic [4:0]  regAddr;
    logic [7:0]  regWriteData, regReadData, ev, e1, d1;
    logic [7:0]  expQ[$];
    logic [1:0]  sleepMode;
    logic [2:0]  portIrq;
    logic [20:0] pinIn, pinOut, pinOe, pinPullUp, pinPullDown, periphOut, periphOe, periphIn;
    logic [20:0] extVal;
    int          n_mismatch, tests_run, b;

    gpio_ports gpio_ports_i (.mclk(mclk), .reset(reset), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
        .regReadModify(regReadModify), .regReadData(regReadData), .sleepMode(sleepMode),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .pinPullUp(pinPullUp),
        .pinPullDown(pinPullDown), .periphOut(periphOut), .periphOe(periphOe),
        .periphIn(periphIn), .portIrq(portIrq), .wakeRequest(wakeRequest));
    gpio_pin_model gpio_pin_model_i (.mclk(mclk), .pinOut(pinOut), .pinOe(pinOe),
        .pinPullUp(pinPullUp), .pinPullDown(pinPullDown), .extEn(21'h1fffff),
        .extVal(extVal), .pinIn(pinIn));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One bus cycle; every strobe is set each edge, so no signal is assigned twice
    task automatic bus(input logic w, r, m, input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWrite <= w;
        regRead <= r;
        regReadModify <= m;
        regAddr <= a;
        regWriteData <= d;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, 1'b0, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic m, input logic [7:0] e);
        expQ.push_back(e);
        bus(1'b0, 1'b1, m, a, 8'h00);
    endtask
    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 1'b0, 5'h00, 8'h00);
    endtask
    task automatic waitWake();
        int k;
        for (k = 0; k < 8 && wakeRequest !== 1'b1; k++) @(posedge mclk);
        if (k == 8) begin
            n_mismatch++;
            $display("BAD wakeRequest expected 1 seen %b", wakeRequest);
            stop_test();
        end
    endtask
    // Read data stand one cycle after the strobe; the oldest note is its expectation
    initial begin
        rdSeen = 1'b0;
        forever begin
            @(posedge mclk);
            if (rdSeen) chk("read data", 21'(expQ.pop_front()), 21'(regReadData));
            rdSeen = regRead;
        end
    end

    initial begin
        void'($urandom(32'h7d4b));
        e1 = 8'($urandom);
        reset = 1'b1;
        sleepMode = 2'h0;
        periphOut = 21'($urandom);
        periphOe = 21'($urandom);
        extVal = {5'h00, e1, 8'h00};
        bus(1'b0, 1'b0, 1'b0, 5'h00, 8'h00);
        repeat (11) @(posedge mclk);
        reset <= 1'b0;
        chk("pull-up", 21'(PULL_CAPABLE), pinPullUp);
        chk("oe", 21'h0, pinOe);
        rd(ADDR_DIRECTION, 1'b0, 8'h00);
        rd(ADDR_FUNCTION_SEL, 1'b0, 8'h00);
        wr(5'h15, 8'hff);
        rd(5'h15, 1'b0, 8'h00);
        $display("Test reset finished");
        // Outputs switching from low make rising edges with no enables set
        ev = 8'($urandom) | 8'h81;
        wr(ADDR_PORT_DATA, ev);
        wr(ADDR_DIRECTION, 8'hff);
        idle(6);
        chk("oe", 21'h0000ff, pinOe);
        chk("out", 21'(ev), pinOut);
        rd(ADDR_PORT_DATA, 1'b0, ev);
        rd(ADDR_PIN_IRQ_FLAG, 1'b0, ev);
        wr(ADDR_PIN_IRQ_FLAG, 8'hff);
        rd(ADDR_PIN_IRQ_FLAG, 1'b0, ev);
        wr(ADDR_PIN_IRQ_FLAG, 8'h0f);
        rd(ADDR_PIN_IRQ_FLAG, 1'b0, ev & 8'h0f);
        // Port zero common enable on, pin enables off: flags alone must not request
        wr(ADDR_COMMON_IRQ_EN, 8'h01);
        idle(3);
        chk("irq", 21'h0, portIrq);
        d1 = 8'($urandom);
        wr(ADDR_PORT_DATA + 5'h01, d1);
        idle(1);
        rd(ADDR_PORT_DATA + 5'h01, 1'b0, e1);
        rd(ADDR_PORT_DATA + 5'h01, 1'b1, d1);
        $display("Test data finished");
        wr(ADDR_INPUT_MODE + 5'h02, 8'h01);
        wr(ADDR_FUNCTION_SEL + 5'h01, 8'h10);
        wr(ADDR_PULL_DIRECTION, 8'h04);
        idle(3);
        chk("pull-up", 21'h00ec00, pinPullUp);
        chk("pull-down", 21'h1e0000, pinPullDown);
        chk("periph oe", 21'(periphOe[12]), 21'(pinOe[12]));
        chk("periph out", 21'(periphOut[12]), 21'(pinOut[12]));
        $display("Test pulls finished");
        wr(ADDR_DIRECTION, 8'h00);
        wr(ADDR_EDGE_CONTROL, 8'h06);
        rd(ADDR_EDGE_CONTROL, 1'b0, 8'h06);
        // Port one watches falling edges, the others rising ones
        for (int p = 0; p < 3; p++) begin
            b = (p == 1) ? 3 : int'($urandom % ((p == 2) ? 5 : 8));
            extVal[8*p+b] <= (p == 1);
            idle(5);
            wr(ADDR_PIN_IRQ_FLAG + 5'(p), 8'h00);
            wr(ADDR_PIN_IRQ_EN + 5'(p), 8'(1 << b));
            wr(ADDR_COMMON_IRQ_EN, 8'(1 << p));
            extVal[8*p+b] <= (p != 1);
            idle(6);
            chk("irq", 21'(1 << p), portIrq);
            rd(ADDR_PIN_IRQ_FLAG + 5'(p), 1'b0, 8'(1 << b));
            wr(ADDR_COMMON_IRQ_EN, 8'h00);
            idle(3);
            chk("irq", 21'h0, portIrq);
        end
        $display("Test interrupts finished");
        // Port two flag is still set, so enabling its port requests a wake in every sleep mode
        for (int s = 1; s < 4; s++) begin
            sleepMode <= 2'(s);
            idle(2);
            wr(ADDR_DIRECTION + 5'h01, 8'hff);
            idle(3);
            chk("oe in sleep", 21'h0, 21'(pinOe[11:8]));
            wr(ADDR_DIRECTION + 5'h01, 8'h00);
            wr(ADDR_COMMON_IRQ_EN, 8'h04);
            waitWake();
            wr(ADDR_COMMON_IRQ_EN, 8'h00);
            sleepMode <= 2'h0;
            idle(3);
        end
        wr(ADDR_DIRECTION + 5'h01, 8'hff);
        idle(3);
        chk("oe awake", 21'h00000f, 21'(pinOe[11:8]));
        $display("Test sleep finished");
        idle(2);
        stop_test();
    end
endmodule
